// *** rtl/psc_core.sv ***
// Serial control, dividers, lock detect and band select.
// Assumes all pin inputs are asynchronous to clk_i and slower than it.
`timescale 1ns/100ps
module psc_core (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       sclk_i,
  input  wire logic       sdata_i,
  input  wire logic       load_strobe_i,
  input  wire logic       chip_en_i,
  input  wire logic       ref_in_i,
  input  wire logic       fb_in_i,
  output logic [1:0]      prescaler_sel_o,
  output logic [1:0]      antibacklash_o,
  output logic [1:0]      core_current_o,
  output logic [1:0]      output_level_o,
  output logic            halve_output_o,
  output logic            halving_select_o,
  output logic            output_on_o,
  output logic            cp_tristate_o,
  output logic            lock_o,
  output logic            tuning_voltage_sel_o,
  output logic [2:0]      band_o,
  output logic            test_mux_output_o,
  output logic            test_mux_output_oe_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] s1_ff, s2_ff, s3_ff;
  logic       sclk_r, load_r, ref_r, fb_r, sdata_s, ce_s;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_ff <= 6'h00;
      s2_ff <= 6'h00;
      s3_ff <= 6'h00;
    end else begin
      s1_ff <= {fb_in_i, ref_in_i, chip_en_i, load_strobe_i, sdata_i, sclk_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign sclk_r  = s2_ff[0] & ~s3_ff[0];
  assign sdata_s = s2_ff[1];
  assign load_r  = s2_ff[2] & ~s3_ff[2];
  assign ce_s    = s2_ff[3];
  assign ref_r   = s2_ff[4] & ~s3_ff[4];
  assign fb_r    = s2_ff[5] & ~s3_ff[5];
  // ----------------------------------------
  // Shift register and latches
  // ----------------------------------------
  logic [23:0] sr_ff, ctl_ff, ref_ff, fbw_ff, tst_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) sr_ff <= psc_pkg::WORD_RST;
    else if (sclk_r) sr_ff <= {sr_ff[22:0], sdata_s};
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_ff <= psc_pkg::WORD_RST;
      ref_ff <= psc_pkg::WORD_RST;
      fbw_ff <= psc_pkg::WORD_RST;
      tst_ff <= psc_pkg::WORD_RST;
    end else if (load_r) begin
      case (sr_ff[1:0])
        psc_pkg::SEL_CTL: ctl_ff <= sr_ff;
        psc_pkg::SEL_REF: ref_ff <= sr_ff;
        psc_pkg::SEL_FB:  fbw_ff <= sr_ff;
        default:          tst_ff <= sr_ff;
      endcase
    end
  end
  wire fb_wr = load_r && (sr_ff[1:0] == psc_pkg::SEL_FB);
  wire cnt_rst = ctl_ff[psc_pkg::CTL_CR] | ~ce_s;
  // ----------------------------------------
  // Reference counter and band clock
  // ----------------------------------------
  logic [13:0] r_cnt_ff;
  logic [2:0]  bd_cnt_ff;
  logic        rp_ff;
  wire  [13:0] r_div = ref_ff[psc_pkg::REF_R +: 14];
  wire  [2:0]  bd_max = 3'((4'h1 << ref_ff[psc_pkg::REF_BSC +: 2]) - 4'h1);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_cnt_ff <= 14'h0000;
      rp_ff    <= 1'b0;
    end else begin
      rp_ff <= 1'b0;
      if (cnt_rst) r_cnt_ff <= 14'h0000;
      else if (ref_r) begin
        if (r_cnt_ff + 14'h0001 >= r_div) begin
          r_cnt_ff <= 14'h0000;
          rp_ff    <= 1'b1;
        end else begin
          r_cnt_ff <= r_cnt_ff + 14'h0001;
        end
      end
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) bd_cnt_ff <= 3'h0;
    else if (rp_ff) bd_cnt_ff <= (bd_cnt_ff >= bd_max) ? 3'h0 : bd_cnt_ff + 3'h1;
  end
  wire band_tick = rp_ff && (bd_cnt_ff >= bd_max);
  // ----------------------------------------
  // Prescaler with A and B counters
  // ----------------------------------------
  function automatic logic [5:0] pmod(input logic [1:0] sel);
    pmod = (sel == 2'h0) ? 6'h08 : (sel == 2'h1) ? 6'h10 : 6'h20;
  endfunction
  logic [5:0]  pre_ff;
  logic [12:0] b_ff;
  logic [4:0]  a_ff;
  logic        np_ff;
  wire  [12:0] b_ld = fbw_ff[psc_pkg::FB_B +: 13];
  wire  [4:0]  a_ld = fbw_ff[psc_pkg::FB_A +: 5];
  wire  [5:0]  p_now = pmod(ctl_ff[psc_pkg::CTL_PRE +: 2]) + {5'h00, a_ff != 5'h00};
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_ff <= 6'h00;
      b_ff   <= 13'h0000;
      a_ff   <= 5'h00;
      np_ff  <= 1'b0;
    end else if (cnt_rst || fb_wr) begin
      pre_ff <= 6'h00;
      b_ff   <= b_ld;
      a_ff   <= a_ld;
      np_ff  <= 1'b0;
    end else begin
      np_ff <= 1'b0;
      if (fb_r) begin
        if (pre_ff + 6'h01 >= p_now) begin
          pre_ff <= 6'h00;
          if (b_ff <= 13'h0001) begin
            b_ff  <= b_ld;
            a_ff  <= a_ld;
            np_ff <= 1'b1;
          end else begin
            b_ff <= b_ff - 13'h0001;
            if (a_ff != 5'h00) a_ff <= a_ff - 5'h01;
          end
        end else begin
          pre_ff <= pre_ff + 6'h01;
        end
      end
    end
  end
  // ----------------------------------------
  // Phase error measure and lock detect
  // ----------------------------------------
  logic       rs_ff, ns_ff, lock_ff;
  logic [3:0] err_ff;
  logic [2:0] good_ff;
  wire pd_done = (rp_ff && np_ff) || (rp_ff && ns_ff) || (np_ff && rs_ff);
  wire [3:0] err = (rp_ff && np_ff) ? 4'h0 : err_ff;
  wire [2:0] need = ref_ff[psc_pkg::REF_LDP] ? psc_pkg::LOCK_N_HI : psc_pkg::LOCK_N_LO;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rs_ff  <= 1'b0;
      ns_ff  <= 1'b0;
      err_ff <= 4'h0;
    end else if (pd_done || cnt_rst) begin
      rs_ff  <= 1'b0;
      ns_ff  <= 1'b0;
      err_ff <= 4'h0;
    end else begin
      rs_ff <= rs_ff | rp_ff;
      ns_ff <= ns_ff | np_ff;
      if ((rs_ff || ns_ff || rp_ff || np_ff) && err_ff != 4'hf) err_ff <= err_ff + 4'h1;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      good_ff <= 3'h0;
      lock_ff <= 1'b0;
    end else if (pd_done) begin
      if (err < psc_pkg::LOCK_CYC) begin
        if (good_ff + 3'h1 >= need) lock_ff <= 1'b1;
        if (good_ff != 3'h7) good_ff <= good_ff + 3'h1;
      end else begin
        good_ff <= 3'h0;
      end
      if (err > psc_pkg::UNLOCK_CYC) lock_ff <= 1'b0;
    end
  end
  // ----------------------------------------
  // Automatic band selection
  // ----------------------------------------
  psc_pkg::psc_band_e bs_ff;
  logic [2:0] bt_ff, band_ff, bit_ff;
  logic [3:0] nct_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bs_ff <= psc_pkg::BS_RUN;
      bt_ff <= 3'h0;
    end else if (fb_wr) begin
      bs_ff <= psc_pkg::BS_RUN;
      bt_ff <= 3'h0;
    end else begin
      case (bs_ff)
        psc_pkg::BS_RUN: if (band_tick) begin
          bt_ff <= bt_ff + 3'h1;
          if (bt_ff + 3'h1 >= psc_pkg::BAND_TICKS) bs_ff <= psc_pkg::BS_END;
        end
        default: bs_ff <= psc_pkg::BS_IDLE;
      endcase
    end
  end
  // Binary search: too many feedback pulses per tick means band too high
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      band_ff <= psc_pkg::BAND_MID;
      bit_ff  <= psc_pkg::BAND_MID;
      nct_ff  <= 4'h0;
    end else if (fb_wr) begin
      band_ff <= psc_pkg::BAND_MID;
      bit_ff  <= psc_pkg::BAND_MID;
      nct_ff  <= 4'h0;
    end else if (bs_ff == psc_pkg::BS_RUN) begin
      if (band_tick) begin
        nct_ff <= 4'h0;
        if (bt_ff != 3'h0 && bit_ff != 3'h0) begin
          band_ff <= (nct_ff > 4'h1) ? (band_ff & ~bit_ff) | (bit_ff >> 1)
                                     : band_ff | (bit_ff >> 1);
          bit_ff  <= bit_ff >> 1;
        end
      end else if (np_ff && nct_ff != 4'hf) nct_ff <= nct_ff + 4'h1;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic mux_ff, mux_oe_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mux_ff    <= 1'b0;
      mux_oe_ff <= 1'b0;
    end else begin
      mux_oe_ff <= 1'b1;
      mux_ff    <= 1'b0;
      case (ctl_ff[psc_pkg::CTL_MUX +: 3])
        3'h0: mux_oe_ff <= 1'b0;
        3'h1: mux_ff <= lock_ff;
        3'h2: mux_ff <= np_ff;
        3'h3: mux_ff <= 1'b1;
        3'h4: mux_ff <= rp_ff;
        3'h5: mux_oe_ff <= ~lock_ff; // Open drain, low while unlocked
        3'h6: mux_ff <= sr_ff[23];
        default: mux_ff <= 1'b0;
      endcase
    end
  end
  assign test_mux_output_o    = mux_ff;
  assign test_mux_output_oe_o = mux_oe_ff;
  assign prescaler_sel_o  = ctl_ff[psc_pkg::CTL_PRE +: 2];
  assign antibacklash_o   = ref_ff[psc_pkg::REF_ABP +: 2];
  assign core_current_o   = ctl_ff[psc_pkg::CTL_CORE +: 2];
  assign output_level_o   = ctl_ff[psc_pkg::CTL_LVL +: 2];
  assign halve_output_o   = fbw_ff[psc_pkg::FB_HALF];
  assign halving_select_o = fbw_ff[psc_pkg::FB_HSEL];
  assign output_on_o = ce_s & ~(ctl_ff[psc_pkg::CTL_MUTE_UNTIL_LOCK] & ~lock_ff);
  assign cp_tristate_o = ~ce_s;
  assign lock_o = lock_ff;
  assign tuning_voltage_sel_o = (bs_ff == psc_pkg::BS_RUN);
  assign band_o = band_ff;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb_chk @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ctl_load;
    load_r && sr_ff[1:0] == psc_pkg::SEL_CTL;
  endsequence
  property p_shift;
    sclk_r |=> sr_ff[0] == $past(sdata_s);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit lost");
  property p_ctl_load;
    s_ctl_load |=> ctl_ff == $past(sr_ff);
  endproperty
  a_ctl_load: assert property (p_ctl_load) else $error("control latch not loaded");
  property p_hold;
    !load_r |=> $stable(ctl_ff) && $stable(fbw_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved without load");
  property p_lock_lo;
    $rose(lock_ff) && !ref_ff[psc_pkg::REF_LDP] |-> $past(good_ff) >= 3'h2;
  endproperty
  a_lock_lo: assert property (p_lock_lo) else $error("early lock");
  property p_lock_hi;
    $rose(lock_ff) && ref_ff[psc_pkg::REF_LDP] |-> $past(good_ff) >= 3'h4;
  endproperty
  a_lock_hi: assert property (p_lock_hi) else $error("early precise lock");
  property p_unlock;
    pd_done && err > psc_pkg::UNLOCK_CYC |=> !lock_ff;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock held on error");
  property p_band;
    fb_wr |=> tuning_voltage_sel_o;
  endproperty
  a_band: assert property (p_band) else $error("band select not started");
  property p_mute;
    ctl_ff[psc_pkg::CTL_MUTE_UNTIL_LOCK] && !lock_ff |-> !output_on_o;
  endproperty
  a_mute: assert property (p_mute) else $error("output on before lock");
  property p_ce;
    !ce_s |-> cp_tristate_o && !output_on_o;
  endproperty
  a_ce: assert property (p_ce) else $error("active while disabled");
endmodule

// *** include/psc_pkg.sv ***
// Constants for the synthesizer serial control block.
// Assumes one 20 MHz system clock.
package psc_pkg;
  // ----------------------------------------
  // Serial word and latch selection
  // ----------------------------------------
  localparam int        SR_W    = 24;
  localparam logic [1:0] SEL_CTL = 2'h0;
  localparam logic [1:0] SEL_REF = 2'h1;
  localparam logic [1:0] SEL_FB  = 2'h2;
  localparam logic [1:0] SEL_TST = 2'h3;
  localparam logic [23:0] WORD_RST = 24'h00_0000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_PRE   = 22; // 2 bits
  localparam int CTL_LVL   = 12; // 2 bits
  localparam int CTL_MUTE_UNTIL_LOCK  = 11;
  localparam int CTL_MUX   = 5;  // 3 bits
  localparam int CTL_CR    = 4;
  localparam int CTL_CORE  = 2;  // 2 bits
  localparam int FB_HSEL   = 23;
  localparam int FB_HALF   = 22;
  localparam int FB_B      = 8;  // 13 bits
  localparam int FB_A      = 2;  // 5 bits
  localparam int REF_BSC   = 20; // 2 bits
  localparam int REF_LDP   = 18;
  localparam int REF_ABP   = 16; // 2 bits
  localparam int REF_R     = 2;  // 14 bits
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS    = 50;
  localparam int LOCK_NS   = 15;
  localparam int UNLOCK_NS = 25;
  localparam logic [3:0] LOCK_CYC =
    4'((LOCK_NS / CLK_NS) < 1 ? 1 : LOCK_NS / CLK_NS);
  localparam logic [3:0] UNLOCK_CYC =
    4'((UNLOCK_NS / CLK_NS) < 1 ? 1 : UNLOCK_NS / CLK_NS);
  localparam logic [2:0] LOCK_N_LO = 3'h3;
  localparam logic [2:0] LOCK_N_HI = 3'h5;
  localparam logic [2:0] BAND_TICKS = 3'h5;
  localparam logic [2:0] BAND_MID  = 3'h4;
  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_RUN  = 2'b01,
    BS_END  = 2'b11
  } psc_band_e;
endpackage

// *** bench/psc_host.sv ***
// Host controller model driving the three-wire programming link.
// Assumes the caller enters send just after a rising edge of clk_i.
`timescale 1ns/100ps
module psc_host (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      load_o
);
  initial begin
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
    load_o  = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // ----------------------------------------
  // One word, optionally loaded; words that select the test latch are not sent
  // ----------------------------------------
  task automatic send(input logic [23:0] word, input bit do_load, input int half);
    if (word[1:0] == psc_pkg::SEL_TST) return;
    for (int i = 23; i >= 0; i--) begin
      sdata_o = word[i];
      hold(half);
      sclk_o = 1'b1;
      hold(half);
      sclk_o = 1'b0;
    end
    // Released data line shows stale inverse
    sdata_o = ~word[0];
    if (do_load) begin
      load_o = 1'b1;
      hold(half + 1);
      load_o = 1'b0;
      hold(half);
    end
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the serial control block.
// Assumes psc_pkg, psc_core and psc_host are compiled first.
`timescale 1ns/100ps
module testbench;
  localparam logic [18:0] M_CFG  = 19'h7_fe00;
  localparam logic [18:0] M_ON   = 19'h0_0100;
  localparam logic [18:0] M_CP   = 19'h0_0080;
  localparam logic [18:0] M_LOCK = 19'h0_0040;
  localparam logic [18:0] M_TUNE = 19'h0_0020;
  localparam logic [18:0] M_BAND = 19'h0_001c;
  localparam logic [18:0] M_MUX  = 19'h0_0003;
  localparam logic [2:0]  MUX_C[5] = '{3'h0, 3'h3, 3'h7, 3'h5, 3'h6};
  localparam logic [18:0] MUX_M[5] = '{19'h0_0001, M_MUX, M_MUX, M_MUX, M_MUX};
  localparam logic [18:0] MUX_V[5] = '{19'h0_0000, 19'h0_0003, 19'h0_0001,
                                       19'h0_0001, 19'h0_0001};

  logic        clk_i;
  logic        sys_rst_i;
  logic        chip_en_i;
  logic        ref_in_i;
  logic        fb_in_i;
  logic        sclk;
  logic        sdata;
  logic        load;
  logic [1:0]  prescaler_sel_o;
  logic [1:0]  antibacklash_o;
  logic [1:0]  core_current_o;
  logic [1:0]  output_level_o;
  logic        halve_output_o;
  logic        halving_select_o;
  logic        output_on_o;
  logic        cp_tristate_o;
  logic        lock_o;
  logic        tuning_voltage_sel_o;
  logic [2:0]  band_o;
  logic        test_mux_output_o;
  logic        test_mux_output_oe_o;
  logic [18:0] obs;
  logic [37:0] note;
  logic [37:0] note_q[$];
  logic        chk_stb;
  int          error_cnt;
  int          cmp_count;
  logic [1:0]  pre, lvl, core, abp;
  logic        half, hsel;
  int          spd, need;

  assign obs = {prescaler_sel_o, antibacklash_o, core_current_o, output_level_o,
                halve_output_o, halving_select_o, output_on_o, cp_tristate_o, lock_o,
                tuning_voltage_sel_o, band_o, test_mux_output_o, test_mux_output_oe_o};

  psc_core dut (
    .clk_i                (clk_i),
    .sys_rst_i            (sys_rst_i),
    .sclk_i               (sclk),
    .sdata_i              (sdata),
    .load_strobe_i        (load),
    .chip_en_i            (chip_en_i),
    .ref_in_i             (ref_in_i),
    .fb_in_i              (fb_in_i),
    .prescaler_sel_o      (prescaler_sel_o),
    .antibacklash_o       (antibacklash_o),
    .core_current_o       (core_current_o),
    .output_level_o       (output_level_o),
    .halve_output_o       (halve_output_o),
    .halving_select_o     (halving_select_o),
    .output_on_o          (output_on_o),
    .cp_tristate_o        (cp_tristate_o),
    .lock_o               (lock_o),
    .tuning_voltage_sel_o (tuning_voltage_sel_o),
    .band_o               (band_o),
    .test_mux_output_o    (test_mux_output_o),
    .test_mux_output_oe_o (test_mux_output_oe_o)
  );

  psc_host host (
    .clk_i   (clk_i),
    .sclk_o  (sclk),
    .sdata_o (sdata),
    .load_o  (load)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic expect_out(input logic [18:0] mask, input logic [18:0] val);
    note_q.push_back({mask, val & mask});
    chk_stb = 1'b1;
    @(negedge clk_i);
    #1;
    chk_stb = 1'b0;
    tick(1);
  endtask

  function automatic logic [23:0] ref_word(input logic lock_precision, input logic [1:0] abp);
    return (24'(lock_precision) << psc_pkg::REF_LDP) | (24'(abp) << psc_pkg::REF_ABP)
         | (24'h00_0001 << psc_pkg::REF_R) | 24'(psc_pkg::SEL_REF);
  endfunction

  function automatic logic [23:0] ctl_word(input logic [1:0] pre, input logic [1:0] lvl,
      input logic mute_until_lock, input logic [2:0] mux, input logic [1:0] core);
    return (24'(pre) << psc_pkg::CTL_PRE) | (24'(lvl) << psc_pkg::CTL_LVL)
         | (24'(mute_until_lock) << psc_pkg::CTL_MUTE_UNTIL_LOCK) | (24'(mux) << psc_pkg::CTL_MUX)
         | (24'(core) << psc_pkg::CTL_CORE) | 24'(psc_pkg::SEL_CTL);
  endfunction

  // Feedback word with B of 3 and A of 0
  function automatic logic [23:0] fb_word(input logic hsel, input logic half);
    return (24'(hsel) << psc_pkg::FB_HSEL) | (24'(half) << psc_pkg::FB_HALF)
         | (24'h00_0003 << psc_pkg::FB_B) | 24'(psc_pkg::SEL_FB);
  endfunction

  task automatic prog_all(input logic [1:0] pre, input logic [1:0] lvl, input logic mute_until_lock,
      input logic [2:0] mux, input logic [1:0] core, input logic lock_precision,
      input logic [1:0] abp, input logic hsel, input logic half, input int spd);
    host.send(ref_word(lock_precision, abp), 1'b1, spd);
    host.send(ctl_word(pre, lvl, mute_until_lock, mux, core), 1'b1, spd);
    host.send(fb_word(hsel, half), 1'b1, spd);
  endtask

  // Phase cycle of 24 feedback edges; reference rise aligned or 2 clk late
  task automatic pd_cycle(input logic late);
    for (int i = 0; i < 24; i++) begin
      fb_in_i  = 1'b1;
      ref_in_i = (i == 23) && !late;
      tick(2);
      fb_in_i  = 1'b0;
      ref_in_i = (i == 23) && late;
      tick(2);
    end
    ref_in_i = 1'b0;
    tick(8);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scoreboard
  // ----------------------------------------
  always @(negedge clk_i) begin
    if (chk_stb && note_q.size() > 0) begin
      note = note_q.pop_front();
      cmp_count++;
      if ((obs & note[37:19]) !== note[18:0]) begin
        error_cnt++;
        $display("[ERR] %0t got %h exp %h", $time, obs & note[37:19], note[18:0]);
      end
    end
  end

  initial begin
    #2_000_000;
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    chip_en_i = 1'b1;
    ref_in_i  = 1'b0;
    fb_in_i   = 1'b0;
    chk_stb   = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(3756));
    tick(20);
    sys_rst_i = 1'b0;
    tick(1);
    expect_out(M_BAND | M_TUNE | M_LOCK | 19'h0_0001, 19'h0_0030);
    tick(4);
    expect_out(M_CP, 19'h0_0000);
    host.send(ctl_word(2'h3, 2'h3, 1'b0, 3'h0, 2'h3), 1'b0, 3);
    expect_out(M_CFG, 19'h0_0000);
    for (int i = 0; i < 4; i++) begin
      pre  = 2'(i);
      lvl  = 2'($urandom);
      core = 2'($urandom);
      abp  = 2'($urandom);
      half = 1'($urandom);
      hsel = 1'($urandom);
      spd  = 3 + int'($urandom_range(3));
      prog_all(pre, lvl, 1'b0, 3'h0, core, 1'b0, abp, hsel, half, spd);
      expect_out(M_CFG, {pre, abp, core, lvl, half, hsel, 9'h000});
      host.send(24'hff_ffff, 1'b1, 3);
      host.send(24'hff_fffc, 1'b0, 3);
      expect_out(M_CFG, {pre, abp, core, lvl, half, hsel, 9'h000});
    end
    for (int m = 0; m < 5; m++) begin
      host.send(ctl_word(2'h0, 2'h0, 1'b0, MUX_C[m], 2'h0), 1'b1, 3);
      expect_out(MUX_M[m], MUX_V[m]);
    end
    for (int p = 0; p < 2; p++) begin
      need = (p == 1) ? 5 : 3;
      prog_all(2'h0, 2'h0, 1'b1, 3'h1, 2'h0, 1'(p), 2'h0, 1'b0, 1'b0, 3);
      expect_out(M_TUNE | M_ON | M_LOCK, M_TUNE);
      for (int k = 1; k <= 6; k++) begin
        pd_cycle(1'b0);
        if (k == need - 1) expect_out(M_LOCK | M_ON, 19'h0_0000);
        if (k == need) expect_out(M_LOCK | M_ON | M_MUX, M_LOCK | M_ON | M_MUX);
      end
      expect_out(M_TUNE | M_LOCK, M_LOCK);
      pd_cycle(1'b1);
      expect_out(M_LOCK, 19'h0_0000);
    end
    chip_en_i = 1'b0;
    tick(4);
    expect_out(M_CP | M_ON, M_CP);
    stop_test();
  end
endmodule
